/* include/mrms_pkg.sv */
// Constants and types for the motor runtime meters and status block.
// Assumes one 25 MHz core clock; every slower rate comes from one divider.
`default_nettype none
package mrms_pkg;
  // ----------------------------------------------------------------
  // Timebase
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned TICK_MS = 100;
  localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam int unsigned METER_MIN = 10;
  localparam logic [12:0] METER_TICKS = 13'(METER_MIN * 60 * 1000 / TICK_MS);
  localparam int unsigned METER_HOURS_MAX = 50_000;
  localparam logic [18:0] METER_MAX = 19'(METER_HOURS_MAX * 60 / METER_MIN);
  // ----------------------------------------------------------------
  // Limits and fixed values
  // ----------------------------------------------------------------
  localparam logic [16:0] STARTS_MAX = 17'h10063;
  localparam logic [7:0] THERMAL_TRIP = 8'h64;
  localparam logic [6:0] SPEED_FULL = 7'h64;
  localparam int unsigned LOG_DEPTH = 5;
  localparam int unsigned NUM_PORTS = 4;
  localparam int unsigned NUM_AUX = 2;
  localparam logic [2:0] NET_PORT = 3'h4;
  localparam logic [3:0] NET_SLOT = 4'h9;
  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_AUXCFG = 8'h04;
  localparam logic [7:0] ADDR_ELAPSED = 8'h08;
  localparam logic [7:0] ADDR_ELAPSED2 = 8'h0C;
  localparam logic [7:0] ADDR_RUNTIME = 8'h10;
  localparam logic [7:0] ADDR_STARTS = 8'h14;
  localparam logic [7:0] ADDR_STATUS = 8'h18;
  localparam logic [7:0] ADDR_STIME = 8'h20;
  localparam logic [7:0] ADDR_PEAK = 8'h40;
  localparam int unsigned CTRL_CLR_BIT = 0;
  localparam logic [7:0] AUXCFG_RESET = 8'h00;
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    FN_NORMAL, FN_UTS, FN_ALARM, FN_FAULT, FN_NET, FN_BRAKE
  } mrms_func_type;
  typedef enum logic [1:0] {
    ST_IDLE, ST_STARTING, ST_RUNNING
  } mrms_state_type;
endpackage : mrms_pkg
`default_nettype wire

/* hw/mrms_core.sv */
// Motor runtime meters, start logs and auxiliary contact outputs.
// Assumes an APB master on core_clk_in and command pulses from same domain.
//
// Notes on behaviour
// - Resettable hour meter saturates, clear zeroes it.
// - Hour meter steps every ten running minutes.
// - Lifetime meter ignores clear, holds at limit.
// - Run timer cleared by start, counts until stop.
// - Keep five start durations, log each event.
// - Start counter counts good starts, saturates 65635.
// - Keep peak start current of last five.
// - Speed estimate only linear modes, else 0/100.
// - Overload fault at thermal usage 100 percent.
// - Both aux contacts selectable NO or NC; bypass and line contacts fixed NO.
// - Normal contact follows start and stop.
// - Up-to-speed contact follows rated speed reached.
// - Alarm contact follows alarm condition.
// - Fault contact follows fault condition.
// - Network contact follows command word bit.
// - Brake contact follows external brake command.
// - First output is fixed NO bypass control.
// - Second output is fixed NO line contactor.
// - First DC input is emergency run request.
// - Four ports usable together; network is port 4.
`timescale 1ns/1ps
`default_nettype none
module mrms_core
  import mrms_pkg::*;
#(
  parameter int unsigned TICK_CYC = TICK_CYCLES
) (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic reset_in,
  // APB slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // Command sources, index 3 is the network port
  input wire logic [NUM_PORTS-1:0] port_start_in,
  input wire logic [NUM_PORTS-1:0] port_stop_in,
  input wire logic [NUM_AUX-1:0] net_aux_cmd_in,
  // Motor and protection status
  input wire logic at_speed_in,
  input wire logic linear_mode_in,
  input wire logic [6:0] speed_est_in,
  input wire logic [15:0] current_avg_in,
  input wire logic [7:0] thermal_cap_in,
  input wire logic alarm_in,
  input wire logic fault_in,
  input wire logic prestart_fault_in,
  input wire logic brake_cmd_in,
  // Pins
  input wire logic emergency_run_input_in,
  // Contacts and status
  output logic bypass_aux_out,
  output logic line_aux_out,
  output logic [NUM_AUX-1:0] aux_out,
  output logic [6:0] speed_out,
  output logic overload_fault_out,
  output logic start_event_out,
  output logic [15:0] start_event_time_out,
  output logic meter_save_out,
  output logic [2:0] last_port_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (reset_in);

  // ----------------------------------------------------------------
  // Timebase
  // ----------------------------------------------------------------
  logic [21:0] div_q;
  logic tick_q;
  logic [12:0] min_q;
  logic ten_min;
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      div_q <= '0;
      tick_q <= 1'b0;
    end else if (div_q == 22'(TICK_CYC - 1)) begin
      div_q <= '0;
      tick_q <= 1'b1;
    end else begin
      div_q <= div_q + 22'h000001;
      tick_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Emergency run input synchroniser
  // ----------------------------------------------------------------
  logic [2:0] emg_sync_q;
  logic emg_q;
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      emg_sync_q <= 3'h0;
      emg_q <= 1'b0;
    end else begin
      emg_sync_q <= {emg_sync_q[1:0], emergency_run_input_in};
      if (emg_sync_q[1] == emg_sync_q[2])
        emg_q <= emg_sync_q[2];
    end
  end
  logic emg_prev_q;
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in)
      emg_prev_q <= 1'b0;
    else
      emg_prev_q <= emg_q;
  end

  // ----------------------------------------------------------------
  // Command merge and start sequence
  // ----------------------------------------------------------------
  // A stop beats a start in the same cycle; emergency run masks stops.
  logic start_req, stop_req, start_go, log_now;
  mrms_state_type state_q;
  assign start_req = (|port_start_in) | (emg_q & ~emg_prev_q);
  assign stop_req = (|port_stop_in) & ~emg_q;
  assign start_go = start_req & ~stop_req & (state_q == ST_IDLE);
  assign log_now = (state_q == ST_STARTING) & at_speed_in & ~stop_req &
                   ~prestart_fault_in;
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      state_q <= ST_IDLE;
    end else begin
      unique case (state_q)
        ST_IDLE: if (start_go) state_q <= ST_STARTING;
        ST_STARTING: begin
          if (stop_req || prestart_fault_in)
            state_q <= ST_IDLE;
          else if (at_speed_in)
            state_q <= ST_RUNNING;
        end
        ST_RUNNING: if (stop_req) state_q <= ST_IDLE;
      endcase
    end
  end
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in)
      last_port_out <= 3'h0;
    else
      for (int i = 0; i < NUM_PORTS; i++)
        if (port_start_in[i] || port_stop_in[i])
          last_port_out <= 3'(i + 1);
  end

  // ----------------------------------------------------------------
  // Hour meters and run timer
  // ----------------------------------------------------------------
  logic running, meter_clr;
  logic [18:0] elapsed_q, life_q, run_q;
  assign running = (state_q != ST_IDLE);
  assign ten_min = tick_q & running & (min_q == METER_TICKS - 13'h0001);
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in)
      min_q <= '0;
    else if (ten_min)
      min_q <= '0;
    else if (tick_q && running)
      min_q <= min_q + 13'h0001;
  end
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      elapsed_q <= '0;
      meter_save_out <= 1'b0;
    end else begin
      meter_save_out <= ten_min;
      if (meter_clr)
        elapsed_q <= '0;
      else if (psel_in && penable_in && pwrite_in &&
               paddr_in == ADDR_ELAPSED)
        elapsed_q <= (pwdata_in[18:0] > METER_MAX) ? METER_MAX :
                     pwdata_in[18:0];
      else if (ten_min && elapsed_q < METER_MAX)
        elapsed_q <= elapsed_q + 19'h00001;
    end
  end
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in)
      life_q <= '0;
    else if (ten_min && life_q < METER_MAX)
      life_q <= life_q + 19'h00001;
  end
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in)
      run_q <= '0;
    else if (start_go)
      run_q <= '0;
    else if (ten_min && run_q != 19'h7FFFF)
      run_q <= run_q + 19'h00001;
  end

  // ----------------------------------------------------------------
  // Start duration, peak current and start counter
  // ----------------------------------------------------------------
  logic [15:0] dur_q, peak_q;
  logic [15:0] stime_q [LOG_DEPTH];
  logic [15:0] speak_q [LOG_DEPTH];
  logic [16:0] starts_q;
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      dur_q <= '0;
      peak_q <= '0;
    end else if (start_go) begin
      dur_q <= '0;
      peak_q <= current_avg_in;
    end else if (state_q == ST_STARTING) begin
      if (tick_q && dur_q != 16'hFFFF)
        dur_q <= dur_q + 16'h0001;
      if (current_avg_in > peak_q)
        peak_q <= current_avg_in;
    end
  end
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      stime_q[0] <= '0;
      speak_q[0] <= '0;
      start_event_out <= 1'b0;
      start_event_time_out <= '0;
    end else begin
      start_event_out <= log_now;
      if (log_now) begin
        stime_q[0] <= dur_q;
        speak_q[0] <= peak_q;
        start_event_time_out <= dur_q;
      end
    end
  end
  for (genvar g = 1; g < LOG_DEPTH; g++) begin : g_log
    always_ff @(posedge core_clk_in or posedge reset_in) begin
      if (reset_in) begin
        stime_q[g] <= '0;
        speak_q[g] <= '0;
      end else if (log_now) begin
        stime_q[g] <= stime_q[g-1];
        speak_q[g] <= speak_q[g-1];
      end
    end
  end
  // A start aborted by a pre-start fault never reaches log_now.
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in)
      starts_q <= '0;
    else if (log_now && !prestart_fault_in && starts_q < STARTS_MAX)
      starts_q <= starts_q + 17'h00001;
  end

  // ----------------------------------------------------------------
  // Speed reading and overload
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      speed_out <= '0;
      overload_fault_out <= 1'b0;
    end else begin
      if (state_q == ST_RUNNING)
        speed_out <= SPEED_FULL;
      else if (linear_mode_in && running)
        speed_out <= speed_est_in;
      else
        speed_out <= '0;
      overload_fault_out <= (thermal_cap_in >= THERMAL_TRIP);
    end
  end

  // ----------------------------------------------------------------
  // Contacts
  // ----------------------------------------------------------------
  logic [7:0] auxcfg_q;
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      bypass_aux_out <= 1'b0;
      line_aux_out <= 1'b0;
    end else begin
      bypass_aux_out <= (state_q == ST_RUNNING);
      line_aux_out <= running;
    end
  end
  for (genvar c = 0; c < NUM_AUX; c++) begin : g_aux
    logic func_level;
    always_comb begin
      unique case (mrms_func_type'(auxcfg_q[4*c +: 3]))
        FN_NORMAL: func_level = running;
        FN_UTS: func_level = (state_q == ST_RUNNING);
        FN_ALARM: func_level = alarm_in;
        FN_FAULT: func_level = fault_in;
        FN_NET: func_level = net_aux_cmd_in[c];
        FN_BRAKE: func_level = brake_cmd_in;
        default: func_level = 1'b0;
      endcase
    end
    always_ff @(posedge core_clk_in or posedge reset_in) begin
      if (reset_in)
        aux_out[c] <= 1'b0;
      else
        aux_out[c] <= func_level ^ auxcfg_q[4*c + 3];
    end
  end

  // ----------------------------------------------------------------
  // APB slave, zero wait states
  // ----------------------------------------------------------------
  logic setup, wr_acc;
  logic [31:0] rd_d;
  logic rd_err;
  assign setup = psel_in & ~penable_in;
  assign wr_acc = psel_in & penable_in & pwrite_in;
  assign meter_clr = wr_acc && paddr_in == ADDR_CTRL &&
                     pwdata_in[CTRL_CLR_BIT];
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in)
      auxcfg_q <= AUXCFG_RESET;
    else if (wr_acc && paddr_in == ADDR_AUXCFG)
      auxcfg_q <= pwdata_in[7:0];
  end
  always_comb begin
    rd_d = 32'h00000000;
    rd_err = 1'b0;
    unique case (paddr_in)
      ADDR_CTRL: rd_d = 32'h00000000;
      ADDR_AUXCFG: rd_d = {24'h000000, auxcfg_q};
      ADDR_ELAPSED: rd_d = {13'h0000, elapsed_q};
      ADDR_ELAPSED2: rd_d = {13'h0000, life_q};
      ADDR_RUNTIME: rd_d = {13'h0000, run_q};
      ADDR_STARTS: rd_d = {15'h0000, starts_q};
      ADDR_STATUS: rd_d = {12'h000, NET_SLOT, last_port_out,
                           overload_fault_out, speed_out, emg_q,
                           line_aux_out, bypass_aux_out, 2'(state_q)};
      default: begin
        rd_err = 1'b1;
        for (int i = 0; i < LOG_DEPTH; i++) begin
          if (paddr_in == ADDR_STIME + 8'(4 * i)) begin
            rd_d = {16'h0000, stime_q[i]};
            rd_err = 1'b0;
          end
          if (paddr_in == ADDR_PEAK + 8'(4 * i)) begin
            rd_d = {16'h0000, speak_q[i]};
            rd_err = 1'b0;
          end
        end
      end
    endcase
  end
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      prdata_out <= '0;
      pslverr_out <= 1'b0;
      pready_out <= 1'b0;
    end else begin
      pready_out <= 1'b1;
      if (setup) begin
        prdata_out <= pwrite_in ? 32'h00000000 : rd_d;
        pslverr_out <= rd_err;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_meter_clear: assert property (meter_clr |=> elapsed_q == 19'h0)
    else $error("hour meter not cleared");
  a_meter_step: assert property (
    ten_min && !meter_clr && elapsed_q < METER_MAX && !wr_acc
    |=> elapsed_q == $past(elapsed_q) + 19'h00001)
    else $error("hour meter did not step");
  a_life_keep: assert property (
    meter_clr && life_q != 19'h0 |=> life_q != 19'h0)
    else $error("lifetime meter cleared");
  a_life_limit: assert property (life_q <= METER_MAX)
    else $error("lifetime meter past limit");
  a_run_clear: assert property (start_go |=> run_q == 19'h0)
    else $error("run timer not cleared");
  a_log_shift: assert property (
    log_now |=> start_event_out && stime_q[1] == $past(stime_q[0])
    && stime_q[0] == $past(dur_q))
    else $error("start log not shifted");
  a_starts_step: assert property (
    log_now && !prestart_fault_in && starts_q < STARTS_MAX
    |=> starts_q == $past(starts_q) + 17'h00001)
    else $error("start count missed");
  a_starts_limit: assert property (starts_q <= STARTS_MAX)
    else $error("start count past limit");
  a_peak_keep: assert property (
    log_now |=> speak_q[0] == $past(peak_q))
    else $error("peak current not kept");
  a_speed_zero: assert property (
    !linear_mode_in && state_q != ST_RUNNING |=> speed_out == 7'h00)
    else $error("speed not zero");
  a_overload_trip: assert property (
    thermal_cap_in >= THERMAL_TRIP |=> overload_fault_out)
    else $error("overload not raised");
  a_bypass_follow: assert property (
    state_q == ST_STARTING ##1 state_q == ST_RUNNING
    |=> bypass_aux_out && line_aux_out)
    else $error("bypass or line contact wrong");
endmodule : mrms_core
`default_nettype wire

/* verif/mrms_far_side.sv */
// Far-side model: operator panels, network adapter and the run pin.
// Assumes the bench calls its tasks from the core clock domain.
`timescale 1ns/1ps
`default_nettype none
module mrms_far_side (
  // Clock
  input wire logic core_clk_in,
  // Commands toward the block
  output logic [3:0] port_start_out,
  output logic [3:0] port_stop_out,
  output logic [1:0] net_aux_cmd_out,
  output logic emergency_run_input_out
);
  initial begin
    port_start_out = 4'h0;
    port_stop_out = 4'h0;
    net_aux_cmd_out = 2'h0;
    emergency_run_input_out = 1'b0;
  end
  // One-cycle pulse from port p (1..4); gap lets a port answer slowly.
  task automatic pulse(input int p, input logic stp, input int gap);
    repeat (gap) @(posedge core_clk_in);
    @(posedge core_clk_in);
    if (stp) port_stop_out[p-1] <= 1'b1;
    else port_start_out[p-1] <= 1'b1;
    @(posedge core_clk_in);
    port_stop_out <= 4'h0;
    port_start_out <= 4'h0;
  endtask : pulse
  // The adapter supplies the command word bits for the contacts.
  task automatic net(input logic [1:0] v);
    @(posedge core_clk_in);
    net_aux_cmd_out <= v;
  endtask : net
  task automatic pin(input logic v);
    @(posedge core_clk_in);
    emergency_run_input_out <= v;
  endtask : pin
endmodule : mrms_far_side
`default_nettype wire

/* verif/mrms_core_tb.sv */
// Self-checking bench for the runtime meters and contact outputs.
// Assumes a short timebase (TC cycles per tick) to keep the run brief.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin \
  fail_count++; $display("mismatch t=%0t got=%h exp=%h", $time, g, e); \
  end end
`define WAITFOR(c) for (int i = 0; i < 30 && !(c); i++) @(negedge clk)
module mrms_core_tb;
  import mrms_pkg::*;
  localparam int unsigned TC = 4;
  logic clk, rst, psel, pen, pwr, pready, pslverr, err;
  logic at_speed, lin, alarm, fault, pre, brake, emerg;
  logic bypass, line, ovl, sev, msave;
  logic [7:0] paddr, therm;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] st, sp;
  logic [1:0] net, aux;
  logic [6:0] sest, speed;
  logic [15:0] cur, stime;
  logic [2:0] lport;
  logic [31:0] ns;
  int fail_count, n_compared;
  mrms_core #(.TICK_CYC(TC)) u_mrms_core (
    .core_clk_in(clk), .reset_in(rst), .psel_in(psel), .penable_in(pen),
    .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .port_start_in(st), .port_stop_in(sp), .net_aux_cmd_in(net),
    .at_speed_in(at_speed), .linear_mode_in(lin), .speed_est_in(sest),
    .current_avg_in(cur), .thermal_cap_in(therm), .alarm_in(alarm),
    .fault_in(fault), .prestart_fault_in(pre), .brake_cmd_in(brake),
    .emergency_run_input_in(emerg), .bypass_aux_out(bypass),
    .line_aux_out(line), .aux_out(aux), .speed_out(speed),
    .overload_fault_out(ovl), .start_event_out(sev),
    .start_event_time_out(stime), .meter_save_out(msave),
    .last_port_out(lport)
  );
  mrms_far_side u_mrms_far_side (
    .core_clk_in(clk), .port_start_out(st), .port_stop_out(sp),
    .net_aux_cmd_out(net), .emergency_run_input_out(emerg)
  );
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // ---------------------------------------------------------------
  // Bus and closing tasks
  // ---------------------------------------------------------------
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do @(posedge clk); while (pready !== 1'b1 && ++n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    if (n >= 20) fail_count++;
  endtask : apb
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(rd, e)
  endtask : rchk
  task automatic summarize();
    $display("compared=%0d mismatches=%0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : summarize
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_bus();
    rchk(ADDR_AUXCFG, {24'h0, AUXCFG_RESET});
    apb(1'b0, 8'hFC, 32'h0);
    `CHK(err, 1'b1)
    apb(1'b1, ADDR_STARTS, 32'h55);
    rchk(ADDR_STARTS, 32'h0);
    apb(1'b1, ADDR_ELAPSED, 32'hFFFFF);
    rchk(ADDR_ELAPSED, {13'h0, METER_MAX});
    apb(1'b1, ADDR_ELAPSED, 32'h0);
    apb(1'b0, ADDR_STATUS, 32'h0);
    `CHK(rd[19:16], NET_SLOT)
    $display("test bus done");
  endtask : t_bus
  task automatic t_start();
    apb(1'b1, ADDR_AUXCFG, 32'h90);
    cur <= 16'h0123;
    lin <= 1'b1;
    sest <= 7'h25;
    u_mrms_far_side.pulse(1, 1'b0, 0);
    @(negedge clk);
    `CHK(line, 1'b0)
    @(negedge clk);
    `CHK(line, 1'b1)
    `CHK(lport, 3'h1)
    `CHK(aux, 2'h3)
    `CHK(bypass, 1'b0)
    `WAITFOR((speed === 7'h25));
    `CHK(speed, 7'h25)
    @(posedge clk);
    lin <= 1'b0;
    cur <= 16'h0456;
    `WAITFOR((speed === 7'h00));
    `CHK(speed, 7'h00)
    repeat (30) @(posedge clk);
    cur <= 16'h0200;
    at_speed <= 1'b1;
    `WAITFOR((sev === 1'b1));
    `CHK((stime >= 16'd8 && stime <= 16'd12), 1'b1)
    @(negedge clk);
    `CHK(sev, 1'b0)
    `WAITFOR((bypass === 1'b1));
    `CHK(bypass, 1'b1)
    `CHK(speed, SPEED_FULL)
    `CHK(aux, 2'h1)
    ns = ns + 1;
    rchk(ADDR_PEAK, 32'h456);
    rchk(ADDR_STARTS, ns);
    $display("test start done");
  endtask : t_start
  task automatic t_meter();
    for (int i = 0; i < 6000 * TC + 100 && msave !== 1'b1; i++)
      @(negedge clk);
    `CHK(msave, 1'b1)
    @(negedge clk);
    `CHK(msave, 1'b0)
    rchk(ADDR_ELAPSED, 32'h1);
    rchk(ADDR_ELAPSED2, 32'h1);
    rchk(ADDR_RUNTIME, 32'h1);
    apb(1'b1, ADDR_CTRL, 32'h1);
    rchk(ADDR_ELAPSED, 32'h0);
    rchk(ADDR_ELAPSED2, 32'h1);
    u_mrms_far_side.pulse(1, 1'b1, 0);
    at_speed <= 1'b0;
    `WAITFOR((line === 1'b0));
    `CHK(line, 1'b0)
    $display("test meter done");
  endtask : t_meter
  task automatic t_restart();
    @(posedge clk);
    cur <= 16'h0111;
    u_mrms_far_side.pulse(2, 1'b0, 3);
    rchk(ADDR_RUNTIME, 32'h0);
    repeat (70) @(posedge clk);
    at_speed <= 1'b1;
    `WAITFOR((sev === 1'b1));
    `CHK((stime >= 16'd17 && stime <= 16'd22), 1'b1)
    `CHK(lport, 3'h2)
    rchk(ADDR_PEAK, 32'h111);
    rchk(ADDR_PEAK + 8'h04, 32'h456);
    apb(1'b0, ADDR_STIME + 8'h04, 32'h0);
    `CHK((rd >= 32'd8 && rd <= 32'd12), 1'b1)
    u_mrms_far_side.pulse(2, 1'b1, 0);
    at_speed <= 1'b0;
    ns = ns + 1;
    $display("test restart done");
  endtask : t_restart
  task automatic t_abort();
    u_mrms_far_side.pulse(3, 1'b0, 0);
    `WAITFOR((line === 1'b1));
    @(posedge clk);
    pre <= 1'b1;
    at_speed <= 1'b1;
    `WAITFOR((line === 1'b0));
    `CHK(line, 1'b0)
    `CHK((stime >= 16'd17 && stime <= 16'd22), 1'b1)
    @(posedge clk);
    pre <= 1'b0;
    at_speed <= 1'b0;
    rchk(ADDR_STARTS, ns);
    `CHK(lport, 3'h3)
    $display("test abort done");
  endtask : t_abort
  task automatic t_emerg();
    u_mrms_far_side.pin(1'b1);
    `WAITFOR((line === 1'b1));
    `CHK(line, 1'b1)
    u_mrms_far_side.pulse(4, 1'b1, 0);
    repeat (4) @(negedge clk);
    `CHK(line, 1'b1)
    u_mrms_far_side.pin(1'b0);
    u_mrms_far_side.pulse(4, 1'b1, 4);
    `WAITFOR((line === 1'b0));
    `CHK(line, 1'b0)
    `CHK(lport, NET_PORT)
    $display("test emergency done");
  endtask : t_emerg
  task automatic t_aux();
    logic [1:0] e;
    for (int f = 2; f < 6; f++) begin
      for (int nc = 0; nc < 2; nc++) begin
        apb(1'b1, ADDR_AUXCFG, {24'h0, nc[0], f[2:0], nc[0], f[2:0]});
        for (int v = 0; v < 2; v++) begin
          @(posedge clk);
          if (f == 2) alarm <= v[0];
          if (f == 3) fault <= v[0];
          if (f == 5) brake <= v[0];
          if (f == 4) u_mrms_far_side.net({v[0], v[0]});
          e = {2{v[0] ^ nc[0]}};
          `WAITFOR((aux === e));
          `CHK(aux, e)
        end
      end
    end
    @(posedge clk);
    therm <= THERMAL_TRIP - 8'h01;
    repeat (4) @(negedge clk);
    `CHK(ovl, 1'b0)
    @(posedge clk);
    therm <= THERMAL_TRIP;
    `WAITFOR((ovl === 1'b1));
    `CHK(ovl, 1'b1)
    $display("test aux done");
  endtask : t_aux
  initial begin
    {rst, psel, pen, pwr, at_speed, lin, alarm, fault, pre, brake} = '0;
    rst = 1'b1;
    paddr = 8'h00;
    pwdata = 32'h0;
    therm = 8'h00;
    sest = 7'h00;
    cur = 16'h0000;
    ns = 32'h0;
    fail_count = 0;
    n_compared = 0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    t_bus();
    t_start();
    t_meter();
    t_restart();
    t_abort();
    t_emerg();
    t_aux();
    summarize();
  end
  initial begin
    repeat (90000) @(posedge clk);
    fail_count++;
    summarize();
  end
endmodule : mrms_core_tb
`default_nettype wire
